/* File: common/ocf_pkg.sv */
// Package for the overcurrent fault logic: constants, modes and the bus port bundle
package ocf_pkg;
  localparam int CLK_MHZ = 100;
  localparam int AW = 4;
  // Register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_THR = 4'h1;
  localparam logic [3:0] REG_STAT = 4'h2;
  localparam logic [3:0] REG_CLR = 4'h3;
  // Control field positions
  localparam int F_BLANK = 0;
  localparam int F_REF = 4;
  localparam int F_DEGL = 6;
  localparam int F_TRDIS = 10;
  localparam int F_FCNT = 11;
  localparam int F_LATCH = 13;
  localparam int F_OCPEN = 14;
  localparam int F_BRAKE = 15;
  localparam logic [15:0] CTRL_RST = 16'h0c00;
  localparam logic [15:0] THR_RST = 16'h0000;
  // Blanking step of 50 ns per code unit, deglitch step of 100 ns per code unit
  localparam int BLANK_STEP_NS = 50;
  localparam int DEGL_STEP_NS = 100;
  localparam int BLANK_STEP_CYC = (BLANK_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int DEGL_STEP_CYC = (DEGL_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] COUNT_8 = 4'h8;
  localparam logic [4:0] COUNT_16 = 5'h10;
  localparam logic [1:0] QUIET_CYCLES = 2'h3;
  typedef enum logic [1:0] {
    OCF_NEVER = 2'h0,
    OCF_EVERY = 2'h1,
    OCF_CNT8 = 2'h2,
    OCF_CNT16 = 2'h3
  } ocf_fcnt_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } ocf_bus_t;
endpackage

/* File: verilog/ocf_top.sv */
// Overcurrent fault logic: blanking, thresholds, deglitch, truncation, counting, fault pin
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ocf_top (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire ocf_pkg::ocf_bus_t i_bus,
  output logic [15:0] o_rdata,
  input wire logic [2:0] i_high_side_gate,
  input wire logic [2:0] i_low_side_gate,
  input wire logic [2:0] i_ocp_pos,
  input wire logic [2:0] i_ocp_neg,
  output logic [2:0] o_high_side_gate,
  output logic [2:0] o_low_side_gate,
  output logic o_amp_blank,
  output logic [1:0] o_ref_scale,
  output logic [5:0] o_pos_threshold_code,
  output logic [5:0] o_neg_threshold_code,
  output logic o_fault_out_n
);
  import ocf_pkg::*;

  logic [15:0] ctrl;
  logic [15:0] thr;
  logic [2:0] gh_s1, gh_s2, gh_d;
  logic [2:0] oc_s1, oc_s2;
  logic [2:0] ls_s1, ls_s2;
  logic [2:0] rise, edge_any;
  logic [7:0] blank_cnt;
  logic blank;
  logic [2:0] oc_raw, oc_filt;
  logic [2:0] trunc;
  logic fault, sticky, clr_pend;
  logic [4:0] cnt [3];
  logic [1:0] quiet [3];
  logic [2:0] seen;
  logic [2:0] hit;
  logic period_ok;
  logic oc_any;
  ocf_fcnt_t fsel;
  logic trunc_en, ocp_en, latch_sel, brake_sel;

  assign fsel = ocf_fcnt_t'(ctrl[F_FCNT +: 2]);
  assign trunc_en = ~ctrl[F_TRDIS];
  assign ocp_en = ctrl[F_OCPEN];
  assign latch_sel = ctrl[F_LATCH];
  assign brake_sel = ctrl[F_BRAKE];

  // Control register write; settings apply live
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl <= CTRL_RST;
    end else if (i_ce && i_bus.wr) begin
      if (i_bus.addr == REG_CTRL) begin
        ctrl <= i_bus.wdata;
      end
    end
  end

  // Threshold register write
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      thr <= THR_RST;
    end else if (i_ce && i_bus.wr) begin
      if (i_bus.addr == REG_THR) begin
        thr <= i_bus.wdata;
      end
    end
  end

  // Read port, one cycle latency
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= 16'h0000;
    end else if (i_ce) begin
      if (i_bus.rd) begin
        case (i_bus.addr)
          REG_CTRL: o_rdata <= ctrl;
          REG_THR: o_rdata <= thr;
          REG_STAT: o_rdata <= {10'h000, blank, |trunc, oc_any, clr_pend, fault, sticky};
          default: o_rdata <= 16'h0000;
        endcase
      end else begin
        o_rdata <= 16'h0000;
      end
    end
  end

  // High-side pin synchroniser and edge delay
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      gh_s1 <= 3'h0;
      gh_s2 <= 3'h0;
      gh_d <= 3'h0;
    end else if (i_ce) begin
      gh_s1 <= i_high_side_gate;
      gh_s2 <= gh_s1;
      gh_d <= gh_s2;
    end
  end

  // Comparator pin synchroniser
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      oc_s1 <= 3'h0;
      oc_s2 <= 3'h0;
    end else if (i_ce) begin
      oc_s1 <= i_ocp_pos | i_ocp_neg;
      oc_s2 <= oc_s1;
    end
  end

  // Low-side pin synchroniser
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ls_s1 <= 3'h0;
      ls_s2 <= 3'h0;
    end else if (i_ce) begin
      ls_s1 <= i_low_side_gate;
      ls_s2 <= ls_s1;
    end
  end

  assign rise = gh_s2 & ~gh_d;
  assign edge_any = gh_s2 ^ gh_d;

  // Blanking timer shared by all phases
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      blank_cnt <= 8'h00;
    end else if (i_ce) begin
      if (|edge_any) begin
        blank_cnt <= 8'(ctrl[F_BLANK +: 4] * BLANK_STEP_CYC);
      end else if (blank_cnt != 8'h00) begin
        blank_cnt <= blank_cnt - 8'h01;
      end
    end
  end
  assign blank = (blank_cnt != 8'h00) || (|edge_any);

  // Deglitch filter per phase, bypassed when truncating
  generate
    for (genvar p = 0; p < 3; p++) begin : g_phase
      logic [7:0] dg;
      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          dg <= 8'h00;
          oc_filt[p] <= 1'b0;
        end else if (i_ce) begin
          if (!oc_s2[p]) begin
            dg <= 8'h00;
            oc_filt[p] <= 1'b0;
          end else if (dg >= 8'(ctrl[F_DEGL +: 4] * DEGL_STEP_CYC)) begin
            oc_filt[p] <= 1'b1;
          end else begin
            dg <= dg + 8'h01;
          end
        end
      end
      assign oc_raw[p] = trunc_en ? (oc_s2[p] & ~blank) : oc_filt[p];

      // Per-phase event counter
      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          cnt[p] <= 5'h00;
          quiet[p] <= 2'h0;
          seen[p] <= 1'b0;
        end else if (i_ce) begin
          if (rise[0]) begin
            if (seen[p] || oc_raw[p]) begin
              quiet[p] <= 2'h0;
              if (!hit[p]) begin
                cnt[p] <= cnt[p] + 5'h01;
              end
            end else if (quiet[p] == QUIET_CYCLES - 2'h1) begin
              quiet[p] <= 2'h0;
              // A reached target also restarts, so a pending clear can land
              cnt[p] <= 5'h00;
            end else begin
              quiet[p] <= quiet[p] + 2'h1;
            end
            seen[p] <= 1'b0;
          end else if (oc_raw[p]) begin
            seen[p] <= 1'b1;
          end
        end
      end
      assign hit[p] = (fsel == OCF_CNT8) ? (cnt[p] >= {1'b0, COUNT_8}) :
                      (fsel == OCF_CNT16) ? (cnt[p] >= COUNT_16) : 1'b0;
    end
  endgenerate

  assign oc_any = |oc_raw;

  // Truncation holds all high sides off until next PWM cycle
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      trunc <= 3'h0;
    end else if (i_ce) begin
      if (ocp_en && trunc_en && !brake_sel && oc_any) begin
        trunc <= 3'h7;
      end else if (|rise || !trunc_en || !ocp_en) begin
        trunc <= 3'h0;
      end
    end
  end

  // Fault-free period tracker for latched counting clear
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      period_ok <= 1'b0;
    end else if (i_ce) begin
      if (|oc_raw) begin
        period_ok <= 1'b0;
      end else if (rise[0] && !(|seen)) begin
        period_ok <= 1'b1;
      end else if (rise[0]) begin
        period_ok <= 1'b0;
      end
    end
  end

  // Fault set, latch and clear; set wins over clear
  logic set_ev, clr_wr, clr_ok;
  assign set_ev = ocp_en && ((fsel == OCF_EVERY && oc_any) || (|hit));
  assign clr_wr = i_bus.wr && (i_bus.addr == REG_CLR);
  assign clr_ok = !latch_sel ? 1'b1 :
                  (fsel == OCF_EVERY) ? !oc_any : period_ok;
  // Fault flag
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fault <= 1'b0;
    end else if (i_ce) begin
      if (set_ev) begin
        fault <= 1'b1;
      end else if ((clr_wr || clr_pend) && clr_ok) begin
        fault <= 1'b0;
      end else if (!ocp_en) begin
        fault <= 1'b0;
      end
    end
  end

  // Clear request held until the latch mode allows it
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      clr_pend <= 1'b0;
    end else if (i_ce) begin
      if (set_ev) begin
        clr_pend <= clr_pend | clr_wr;
      end else if ((clr_wr || clr_pend) && clr_ok) begin
        clr_pend <= 1'b0;
      end else if (clr_wr) begin
        clr_pend <= fault;
      end else if (!ocp_en) begin
        clr_pend <= 1'b0;
      end
    end
  end

  // Sticky fault status
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sticky <= 1'b0;
    end else if (i_ce) begin
      if (set_ev) begin
        sticky <= 1'b1;
      end else if (clr_wr && i_bus.wdata[1]) begin
        sticky <= 1'b0;
      end
    end
  end

  // High-side output, truncated or braked
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_high_side_gate <= 3'h0;
    end else if (i_ce) begin
      o_high_side_gate <= (brake_sel && fault) ? 3'h0 : (gh_s2 & ~trunc);
    end
  end

  // Low-side output, all on while braking
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_low_side_gate <= 3'h0;
    end else if (i_ce) begin
      o_low_side_gate <= (brake_sel && fault) ? 3'h7 : ls_s2;
    end
  end

  // Amplifier blanking output
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_amp_blank <= 1'b0;
    end else if (i_ce) begin
      o_amp_blank <= blank;
    end
  end

  // Offset reference scaling
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_ref_scale <= 2'h0;
    end else if (i_ce) begin
      o_ref_scale <= ctrl[F_REF +: 2];
    end
  end

  // Threshold codes for both converters
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pos_threshold_code <= 6'h00;
      o_neg_threshold_code <= 6'h00;
    end else if (i_ce) begin
      o_pos_threshold_code <= thr[5:0];
      o_neg_threshold_code <= thr[13:8];
    end
  end

  // Active-low fault pin
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_fault_out_n <= 1'b1;
    end else if (i_ce) begin
      o_fault_out_n <= ~fault;
    end
  end
endmodule // ocf_top
`default_nettype wire

/* File: verif/ocf_props.sv */
// Port checker for the overcurrent fault logic
`timescale 1ns/1ps
`default_nettype none
module ocf_props (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire ocf_pkg::ocf_bus_t i_bus,
  input wire logic [2:0] i_high_side_gate,
  input wire logic [2:0] i_low_side_gate,
  input wire logic [2:0] o_high_side_gate,
  input wire logic [2:0] o_low_side_gate,
  input wire logic o_amp_blank,
  input wire logic [1:0] o_ref_scale,
  input wire logic [5:0] o_pos_threshold_code,
  input wire logic [5:0] o_neg_threshold_code,
  input wire logic o_fault_out_n
);
  import ocf_pkg::*;
  logic en_q;
  logic [2:0] dis_cnt;
  logic [6:0] quiet_cnt;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // Last written protection enable and cycles spent disabled
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      en_q <= 1'b0;
      dis_cnt <= 3'h0;
    end else begin
      if (i_bus.wr && i_bus.addr == REG_CTRL) en_q <= i_bus.wdata[F_OCPEN];
      if (en_q) dis_cnt <= 3'h0;
      else if (dis_cnt != 3'h7) dis_cnt <= dis_cnt + 3'h1;
    end
  end
  // Cycles since the last high-side change
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) quiet_cnt <= 7'h0;
    else if (i_high_side_gate != $past(i_high_side_gate)) quiet_cnt <= 7'h0;
    else if (quiet_cnt != 7'h7f) quiet_cnt <= quiet_cnt + 7'h1;
  end
  chk_ref_follow: assert property (i_bus.wr && i_bus.addr == REG_CTRL |->
    ##2 o_ref_scale == $past(i_bus.wdata[5:4], 2)) else $error("ref scale not from control write");
  chk_pos_code: assert property (i_bus.wr && i_bus.addr == REG_THR |->
    ##2 o_pos_threshold_code == $past(i_bus.wdata[5:0], 2)) else $error("positive code mismatch");
  chk_neg_code: assert property (i_bus.wr && i_bus.addr == REG_THR |->
    ##2 o_neg_threshold_code == $past(i_bus.wdata[13:8], 2)) else $error("negative code mismatch");
  chk_gate_only: assert property ((o_high_side_gate & ~($past(i_high_side_gate, 2) |
    $past(i_high_side_gate, 3) | $past(i_high_side_gate, 4))) == 3'h0) else $error("high side on without input");
  chk_low_pass: assert property (o_low_side_gate == $past(i_low_side_gate, 3) ||
    o_low_side_gate == 3'h7) else $error("low side neither passed nor braked");
  chk_blank_edge: assert property ($changed(i_high_side_gate) |-> ##[1:6] o_amp_blank)
    else $error("no blanking after high side edge");
  chk_blank_end: assert property (quiet_cnt == 7'h7f |-> !o_amp_blank)
    else $error("blanking outlasts its time");
  chk_off_quiet: assert property (dis_cnt == 3'h7 |-> o_fault_out_n)
    else $error("fault shown while protection disabled");
endmodule // ocf_props
`default_nettype wire

/* File: verif/ocf_mcu_model.sv */
// Microcontroller model: three-phase PWM with dead time
`timescale 1ns/1ps
`default_nettype none
module ocf_mcu_model #(parameter int PERIOD = 40) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_run,
  output logic [2:0] o_high_side_gate,
  output logic [2:0] o_low_side_gate
);
  int cnt;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt <= 0;
      o_high_side_gate <= 3'h0;
      o_low_side_gate <= 3'h0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      o_high_side_gate <= {3{i_run && cnt < PERIOD / 2}};
      o_low_side_gate <= {3{i_run && cnt >= PERIOD / 2 + 2 && cnt < PERIOD - 2}};
    end
  end
endmodule // ocf_mcu_model
`default_nettype wire

/* File: verif/ocf_top_tb_top.sv */
// Testbench for the overcurrent fault logic
`timescale 1ns/1ps
`default_nettype none
module ocf_top_tb_top;
  import ocf_pkg::*;
  typedef struct {logic [3:0] a; logic [15:0] w; logic [15:0] e; logic [15:0] m;} ocf_row_t;
  logic i_clk, i_rstn, run, fault_n;
  ocf_bus_t bus;
  logic [15:0] rdata, d;
  logic [2:0] hs, ls, ocp_p, ocp_n, ohs;
  int errors, total_checks;
  ocf_row_t rows [4] = '{'{REG_THR, 16'hffff, 16'h3f3f, 16'h3f3f}, '{REG_CTRL, 16'h8a5b, 16'h8a5b, 16'hffff},
    '{4'h7, 16'h1234, 16'h0000, 16'hffff}, '{REG_THR, 16'h2a15, 16'h2a15, 16'h3f3f}};
  ocf_top ocf_top_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(1'b1), .i_bus(bus), .o_rdata(rdata),
    .i_high_side_gate(hs), .i_low_side_gate(ls), .i_ocp_pos(ocp_p), .i_ocp_neg(ocp_n),
    .o_high_side_gate(ohs), .o_low_side_gate(), .o_amp_blank(), .o_ref_scale(),
    .o_pos_threshold_code(), .o_neg_threshold_code(), .o_fault_out_n(fault_n));
  ocf_mcu_model #(.PERIOD(40)) ocf_mcu_model_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_run(run),
    .o_high_side_gate(hs), .o_low_side_gate(ls));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] w);
    @(posedge i_clk) bus <= '{a, w, 1'b1, 1'b0};
    @(posedge i_clk) bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge i_clk) bus <= '{a, 16'h0, 1'b0, 1'b1};
    @(posedge i_clk) bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_f(input logic v, input int n);
    for (int i = 0; i < n && fault_n !== v; i++) @(posedge i_clk);
    chk("fault_out_n", {15'h0, v}, {15'h0, fault_n});
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    #200us;
    errors++;
    end_of_test();
  end
  initial begin
    i_rstn = 1'b0; run = 1'b0; bus = '0; ocp_p = 3'h0; ocp_n = 3'h0; errors = 0; total_checks = 0;
    repeat (16) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(REG_CTRL);
    chk("ctrl reset", CTRL_RST, d);
    chk("fault reset", 16'h1, {15'h0, fault_n});
    foreach (rows[k]) begin
      wr(rows[k].a, rows[k].w);
      rd(rows[k].a);
      chk("readback", rows[k].e, d & rows[k].m);
    end
    $display("register test done");
    run <= 1'b1;
    wr(REG_CTRL, 16'h4c00);
    ocp_p <= 3'h2;
    wait_f(1'b0, 200);
    rd(REG_STAT);
    chk("sticky", 16'h1, d & 16'h1);
    ocp_p <= 3'h0;
    wr(REG_CLR, 16'h0);
    wait_f(1'b1, 40);
    rd(REG_STAT);
    chk("sticky kept", 16'h1, d & 16'h1);
    wr(REG_CLR, 16'h2);
    $display("non-latched test done");
    wr(REG_CTRL, 16'h6c00);
    ocp_n <= 3'h4;
    wait_f(1'b0, 200);
    wr(REG_CLR, 16'h0);
    repeat (30) @(posedge i_clk);
    chk("latched hold", 16'h0, {15'h0, fault_n});
    ocp_n <= 3'h0;
    wait_f(1'b1, 100);
    $display("latched test done");
    wr(REG_CTRL, 16'h4400);
    ocp_p <= 3'h7;
    repeat (200) @(posedge i_clk);
    chk("never mode", 16'h1, {15'h0, fault_n});
    ocp_p <= 3'h0;
    repeat (200) @(posedge i_clk);
    wr(REG_CTRL, 16'h5400);
    ocp_p <= 3'h1;
    repeat (240) @(posedge i_clk);
    chk("below eight", 16'h1, {15'h0, fault_n});
    wait_f(1'b0, 160);
    ocp_p <= 3'h0;
    wr(REG_CLR, 16'h0);
    wait_f(1'b1, 200);
    ocp_p <= 3'h1;
    repeat (200) @(posedge i_clk);
    ocp_p <= 3'h0;
    repeat (200) @(posedge i_clk);
    ocp_p <= 3'h1;
    repeat (200) @(posedge i_clk);
    chk("quiet reset", 16'h1, {15'h0, fault_n});
    ocp_p <= 3'h0;
    $display("count test done");
    wr(REG_CTRL, 16'h4800);
    wait (hs == 3'h0);
    wait (hs == 3'h7);
    repeat (8) @(posedge i_clk);
    ocp_p <= 3'h1;
    repeat (6) @(posedge i_clk);
    chk("truncated", 16'h0, {13'h0, ohs});
    ocp_p <= 3'h0;
    wait_f(1'b0, 20);
    wait (hs == 3'h0);
    wait (hs == 3'h7);
    repeat (8) @(posedge i_clk);
    chk("resumed", 16'h7, {13'h0, ohs});
    $display("truncation test done");
    end_of_test();
  end
endmodule // ocf_top_tb_top
bind ocf_top ocf_props ocf_props_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_bus(i_bus),
  .i_high_side_gate(i_high_side_gate), .i_low_side_gate(i_low_side_gate), .o_high_side_gate(o_high_side_gate),
  .o_low_side_gate(o_low_side_gate), .o_amp_blank(o_amp_blank), .o_ref_scale(o_ref_scale),
  .o_pos_threshold_code(o_pos_threshold_code), .o_neg_threshold_code(o_neg_threshold_code),
  .o_fault_out_n(o_fault_out_n));
`default_nettype wire
